// *** design/tss_defs.vh ***
`ifndef TSS_DEFS_VH
`define TSS_DEFS_VH
// Register byte offsets
`define TSS_CMD_OFS 4'h0
`define TSS_STATUS_OFS 4'h4
`define TSS_DATA_OFS 4'h8
`define TSS_PTR_OFS 4'hc
// Function word layout
`define TSS_FW_UNIT_BIT 29
`define TSS_FW_OP_MSB 3
`define TSS_FW_DUMMY 30'h20000000
// Operation codes
`define TSS_OP_SRCH_FWD 4'h1
`define TSS_OP_SRCH_BWD 4'h2
`define TSS_OP_XFER_IN 4'h3
`define TSS_OP_XFER_OUT 4'h4
`define TSS_OP_WIND 4'h5
`define TSS_OP_WIND_IL 4'h6
`define TSS_OP_REWIND 4'h7
`define TSS_OP_REWIND_IL 4'h8
// Status bit positions
`define TSS_ST_REPORT 0
`define TSS_ST_AVAIL 1
`define TSS_ST_READY 2
`define TSS_ST_EQ_FIND 3
`define TSS_ST_UNEQ_FIND 4
`define TSS_ST_INTERLOCK 5
`define TSS_ST_ERROR 6
`define TSS_ST_REFUSED 7
`define TSS_ST_EOT 8
`define TSS_ST_BOT 9
`define TSS_ST_EOF 10
// Blockette geometry
`define TSS_WORDS 5'd24
`define TSS_LAST_WORD 5'd23
`define TSS_CHARS 7'd120
`define TSS_CHARS_PER_WORD 3'd5
`define TSS_IGNORE 6'h00
`endif

// *** design/tss_sequencer.v ***
// Our own choices: the AHB-Lite slave port and the register addresses.
`include "tss_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tss_sequencer (
  input wire hclk, // Bus clock, 100 MHz
  input wire hresetn, // Async reset, active low
  input wire ce, // Clock enable, freezes all state when low
  input wire hsel, // Slave select
  input wire [31:0] haddr, // Byte address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write when high
  input wire [2:0] hsize, // Transfer size, word only
  input wire [31:0] hwdata, // Write data
  input wire hready, // Bus ready
  output wire hreadyout, // Always ready, no wait states
  output wire hresp, // Always OKAY
  output reg [31:0] hrdata, // Read data
  input wire tape_char_valid, // One tape character this cycle
  input wire [5:0] tape_char, // Character from read head
  input wire tape_par_err, // Parity error on this character
  input wire tape_gap, // Pulse at inter-blockette gap
  input wire tape_eot, // End of tape marker
  input wire tape_bot, // Beginning of tape marker
  input wire tape_eof, // End of file or data sentinel
  input wire panel_clear, // Manual clear from unit panel
  output reg tape_fwd, // Drive tape forward
  output reg tape_rev, // Drive tape in reverse
  output reg error_lamp, // Unit error indicator
  output reg interlock, // Unit locked out
  output reg report_int, // Status report pending
  output wire unit_ready, // Tape unit ready
  output reg adapter_available // Channel adapter available
);
  localparam S_IDLE = 3'd0;
  localparam S_LOAD = 3'd1;
  localparam S_SEND = 3'd2;
  localparam S_SEARCH = 3'd3;
  localparam S_REPOS = 3'd4;
  localparam S_WIND = 3'd5;
  localparam S_REWIND = 3'd6;
  localparam S_HANG = 3'd7;
  reg [2:0] state;
  reg [3:0] op;
  reg [5:0] buf_mem [0:119];
  reg [4:0] word_ptr;
  reg [6:0] ch_cnt;
  reg svc_ok;
  reg decided;
  reg greater;
  reg par_seen;
  reg eq_find;
  reg uneq_find;
  reg refused;
  reg wr_pend;
  reg [3:0] wr_ofs;
  reg [31:0] rd_word;
  reg [6:0] base;
  reg [31:0] status_word;
  wire [6:0] next_idx = ch_cnt + 7'd1; // Next character index
  integer i;
  integer j;
  wire acc = ce & hsel & htrans[1] & hready;
  wire rd_acc = acc & ~hwrite;
  wire wr_now = ce & wr_pend;
  wire cmd_wr = wr_now & (wr_ofs == `TSS_CMD_OFS);
  wire ack_wr = wr_now & (wr_ofs == `TSS_STATUS_OFS) & hwdata[`TSS_ST_REPORT];
  wire data_wr = wr_now & (wr_ofs == `TSS_DATA_OFS) & (state == S_LOAD);
  wire data_rd = rd_acc & (haddr[3:0] == `TSS_DATA_OFS) & (state == S_SEND);
  wire addressed = hwdata[`TSS_FW_UNIT_BIT];
  wire [3:0] fw_op = hwdata[`TSS_FW_OP_MSB:0];
  wire cmd_ok = cmd_wr & addressed & adapter_available & ~report_int & ~interlock
    & (state == S_IDLE); // Host discipline still checked here
  wire is_dummy = hwdata[29:0] == `TSS_FW_DUMMY;
  wire [5:0] id_ch = buf_mem[ch_cnt];
  wire fwd_srch = (op == `TSS_OP_SRCH_FWD);
  wire lock_op = (op == `TSS_OP_WIND_IL) | (op == `TSS_OP_REWIND_IL);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign unit_ready = (state == S_IDLE) & ~interlock;
  // Word w holds chars at (23-w)*5 onward, so word 23 char 4 is char 0
  always @* begin
    base = 7'd0;
    for (i = 0; i < 24; i = i + 1) begin
      if (word_ptr == i[4:0]) begin
        base = 7'd115 - i[6:0] * 7'd5;
      end
    end
    rd_word = 32'h00000000;
    for (i = 0; i < 5; i = i + 1) begin
      rd_word[i*6 +: 6] = buf_mem[base + 7'd4 - i[6:0]];
    end
  end
  // Status image, terminal conditions shown live for dummy probes
  always @* begin
    status_word = 32'h00000000;
    status_word[`TSS_ST_REPORT] = report_int;
    status_word[`TSS_ST_AVAIL] = adapter_available;
    status_word[`TSS_ST_READY] = unit_ready;
    status_word[`TSS_ST_EQ_FIND] = eq_find;
    status_word[`TSS_ST_UNEQ_FIND] = uneq_find;
    status_word[`TSS_ST_INTERLOCK] = interlock;
    status_word[`TSS_ST_ERROR] = error_lamp;
    status_word[`TSS_ST_REFUSED] = refused;
    status_word[`TSS_ST_EOT] = tape_eot;
    status_word[`TSS_ST_BOT] = tape_bot;
    status_word[`TSS_ST_EOF] = tape_eof; // Terminal condition visible
  end

  // Address phase capture and registered read data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_ofs <= 4'h0;
      hrdata <= 32'h00000000;
    end else if (ce) begin
      if (hready) begin
        wr_pend <= acc & hwrite;
        wr_ofs <= haddr[3:0];
      end
      if (rd_acc) begin
        case (haddr[3:0])
          `TSS_STATUS_OFS: hrdata <= status_word;
          `TSS_DATA_OFS: hrdata <= (state == S_SEND) ? {2'b00, rd_word[29:0]} : 32'h00000000;
          `TSS_PTR_OFS: hrdata <= {27'h0000000, word_ptr};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Buffer memory, no reset needed for data storage
  always @(posedge hclk) begin
    if (data_wr) begin
      for (j = 0; j < 5; j = j + 1) begin
        buf_mem[base + 7'd4 - j[6:0]] <= hwdata[j*6 +: 6]; // Output list loaded
      end
    end
  end

  // Main sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      op <= 4'h0;
      word_ptr <= 5'd0;
      ch_cnt <= 7'd0;
      svc_ok <= 1'b1;
      decided <= 1'b0;
      greater <= 1'b0;
      par_seen <= 1'b0;
      eq_find <= 1'b0;
      uneq_find <= 1'b0;
      refused <= 1'b0;
      tape_fwd <= 1'b0;
      tape_rev <= 1'b0;
      error_lamp <= 1'b0;
      interlock <= 1'b0;
      report_int <= 1'b0;
      adapter_available <= 1'b1;
    end else if (ce) begin
      // Report set wins over a same-cycle acknowledge
      if (ack_wr) begin
        report_int <= 1'b0;
        refused <= 1'b0;
      end
      if (cmd_wr & addressed & ~cmd_ok) begin
        refused <= 1'b1;
      end
      if (panel_clear) begin
        interlock <= 1'b0; // Manual clear only
        error_lamp <= 1'b0;
        if (state == S_HANG) begin
          state <= S_IDLE; // Motion already off in hang
        end
      end
      case (state)
        S_IDLE: begin
          if (cmd_ok) begin
            op <= fw_op;
            word_ptr <= 5'd0;
            ch_cnt <= 7'd0;
            svc_ok <= 1'b1;
            decided <= 1'b0;
            par_seen <= 1'b0;
            eq_find <= 1'b0;
            uneq_find <= 1'b0;
            adapter_available <= 1'b0;
            if (is_dummy) begin
              adapter_available <= 1'b1; // No operation, report only
              report_int <= 1'b1;
            end else begin
              case (fw_op)
                `TSS_OP_SRCH_FWD, `TSS_OP_SRCH_BWD, `TSS_OP_XFER_OUT: state <= S_LOAD;
                `TSS_OP_XFER_IN: state <= S_SEND; // No tape motion
                `TSS_OP_WIND, `TSS_OP_WIND_IL: begin
                  adapter_available <= 1'b1; // Freed right after relay
                  report_int <= 1'b1;
                  tape_fwd <= ~tape_eot;
                  state <= tape_eot ? S_HANG : S_WIND; // Hang at end of tape
                end
                `TSS_OP_REWIND, `TSS_OP_REWIND_IL: begin
                  adapter_available <= 1'b1; // Freed right after relay
                  report_int <= 1'b1;
                  tape_rev <= ~tape_bot;
                  state <= tape_bot ? S_HANG : S_REWIND; // Hang at beginning
                end
                default: begin
                  adapter_available <= 1'b1; // No data moved, freed at once
                  report_int <= 1'b1;
                end
              endcase
            end
          end
        end
        S_LOAD: begin
          if (data_wr) begin
            word_ptr <= word_ptr + 5'd1;
            if (word_ptr == `TSS_LAST_WORD) begin
              adapter_available <= 1'b1; // Available once block moved
              report_int <= 1'b1;
              if (op == `TSS_OP_XFER_OUT) begin
                state <= S_IDLE;
              end else begin
                state <= S_SEARCH;
                tape_fwd <= fwd_srch; // Forward search motion
                tape_rev <= ~fwd_srch; // Reverse search motion
              end
            end
          end
        end
        S_SEND: begin
          if (data_rd) begin
            word_ptr <= word_ptr + 5'd1;
            if (word_ptr == `TSS_LAST_WORD) begin
              adapter_available <= 1'b1; // Ready once block sent
              report_int <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        S_SEARCH: begin
          if (tape_char_valid && ch_cnt < `TSS_CHARS) begin
            ch_cnt <= next_idx;
            if (ch_cnt == 7'd0) begin
              // Exact match unless ignore code
              svc_ok <= (id_ch == `TSS_IGNORE) | (tape_char == id_ch);
            end else if (!decided && id_ch != `TSS_IGNORE && tape_char != id_ch) begin
              decided <= 1'b1; // Ignore code matches anything
              greater <= tape_char > id_ch; // First difference, unsigned
            end
          end
          if (tape_gap) begin
            ch_cnt <= 7'd0;
            svc_ok <= 1'b1;
            decided <= 1'b0;
            if (svc_ok && (!decided || (greater == fwd_srch))) begin
              eq_find <= ~decided; // Equal or unequal find
              uneq_find <= decided;
              if (fwd_srch) begin
                tape_fwd <= 1'b0;
                tape_rev <= 1'b1; // Back up over found blockette
                state <= S_REPOS;
              end else begin
                tape_rev <= 1'b0; // Backward find ends at start
                state <= S_IDLE;
              end
            end
          end else if (tape_eof || (fwd_srch ? tape_eot : tape_bot)) begin
            tape_fwd <= 1'b0; // No find, search ends
            tape_rev <= 1'b0;
            state <= S_IDLE;
          end
        end
        S_REPOS: begin
          if (tape_gap || tape_bot) begin
            tape_rev <= 1'b0; // Stopped at blockette start
            state <= S_IDLE;
          end
        end
        S_WIND: begin
          if (tape_eot) begin
            tape_fwd <= 1'b0; // Ready only when tape stops
            interlock <= lock_op; // Lock after stop
            state <= S_IDLE;
          end
        end
        S_REWIND: begin
          if (tape_char_valid) begin
            ch_cnt <= next_idx;
            par_seen <= par_seen | tape_par_err;
          end
          if (tape_gap) begin
            ch_cnt <= 7'd0;
            par_seen <= 1'b0;
            if (par_seen || tape_par_err || ch_cnt != `TSS_CHARS) begin
              tape_rev <= 1'b0; // Suspend, light lamp, stay not-ready
              error_lamp <= 1'b1;
              state <= S_HANG;
            end
          end else if (tape_bot) begin
            tape_rev <= 1'b0;
            interlock <= lock_op; // Lock after stop
            state <= S_IDLE;
          end
        end
        S_HANG: begin
          tape_fwd <= 1'b0;
          tape_rev <= 1'b0;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verification/tss_tape_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tss_tape_model (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic tape_fwd, // Forward motion
  input wire logic tape_rev, // Reverse motion
  input wire logic [5:0] mark_char, // First char of every blockette
  input wire logic [4:0] err_blk, // Blockette read with bad parity
  output logic tape_char_valid, // Char strobe
  output logic [5:0] tape_char, // Char value
  output logic tape_par_err, // Parity flag
  output logic tape_gap, // Gap pulse
  output logic tape_eot, // At end of tape
  output logic tape_bot, // At beginning of tape
  output logic [4:0] pos // Gap index, 0 to 16
);
  logic [6:0] idx;
  logic [4:0] blk;
  logic moving;
  // Blockette n holds n in every char but the first
  assign blk = tape_fwd ? pos : pos - 5'd1;
  assign tape_eot = (pos == 5'd16);
  assign tape_bot = (pos == 5'd0);
  assign moving = (tape_fwd && !tape_eot) || (tape_rev && !tape_bot);
  // Handler counts as modified: direction may reverse with no pause
  // One char a cycle, then a gap; data line toggles when idle so no stale value
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos <= 5'd0;
      idx <= 7'd0;
      tape_char_valid <= 1'b0;
      tape_gap <= 1'b0;
      tape_par_err <= 1'b0;
      tape_char <= 6'h00;
    end else begin
      tape_gap <= 1'b0;
      tape_char_valid <= 1'b0;
      tape_par_err <= 1'b0;
      tape_char <= ~tape_char;
      if (!moving) begin
        idx <= 7'd0;
      end else if (idx == 7'd120) begin
        tape_gap <= 1'b1;
        idx <= 7'd0;
        pos <= tape_fwd ? pos + 5'd1 : pos - 5'd1;
      end else begin
        tape_char_valid <= 1'b1;
        tape_char <= (idx == 7'd0) ? mark_char : {1'b0, blk};
        tape_par_err <= (blk == err_blk) && (idx == 7'd60);
        idx <= idx + 7'd1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/tss_sequencer_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module tss_sequencer_chk (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic ce, // Enable
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer
  input wire logic hwrite, // Write
  input wire logic hready, // Ready
  input wire logic [31:0] hwdata, // Data
  input wire logic tape_eot, // End
  input wire logic tape_bot, // Start
  input wire logic panel_clear, // Clear
  input wire logic tape_fwd, // Forward
  input wire logic tape_rev, // Reverse
  input wire logic error_lamp, // Lamp
  input wire logic interlock, // Lock
  input wire logic report_int, // Report
  input wire logic unit_ready, // Ready
  input wire logic adapter_available // Free
);
  logic ph_w;
  logic cmd_w;
  logic go;
  // Data phase of a command write follows its address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_w <= 1'b0;
    end else if (ce) begin
      ph_w <= hsel && htrans[1] && hready && hwrite && (haddr == 32'h0);
    end
  end
  // Only a free, idle, unlocked unit with no report takes a command
  assign cmd_w = ph_w && ce;
  assign go = cmd_w && adapter_available && !report_int && !interlock && unit_ready;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence cmd_s(logic [31:0] v);
    go && (hwdata == v);
  endsequence
  dummy_idle_a: assert property (cmd_s(32'h20000000) |=> report_int && !tape_fwd && !tape_rev)
    else $error("dummy command moved tape");
  wind_start_a: assert property (cmd_s(32'h20000006) ##0 !tape_eot |=>
    report_int && adapter_available ##[0:4] tape_fwd) else $error("wind did not start");
  rewind_start_a: assert property (cmd_s(32'h20000007) ##0 !tape_bot |=>
    report_int && adapter_available ##[0:4] tape_rev) else $error("rewind did not start");
  dir_excl_a: assert property (!(tape_fwd && tape_rev))
    else $error("both directions driven");
  eot_stop_a: assert property (tape_fwd && tape_eot |-> ##[1:3] !tape_fwd)
    else $error("forward past end of tape");
  bot_stop_a: assert property (tape_rev && tape_bot |-> ##[1:3] !tape_rev)
    else $error("reverse past beginning of tape");
  busy_ready_a: assert property (tape_fwd || tape_rev |-> !unit_ready)
    else $error("ready while tape moves");
  lock_hold_a: assert property (interlock && !panel_clear |=> interlock && !unit_ready)
    else $error("interlock dropped");
  lamp_hold_a: assert property (error_lamp && !panel_clear |=> error_lamp && !unit_ready)
    else $error("error hang released");
  refuse_a: assert property (cmd_w && interlock |=>
    !tape_fwd && !tape_rev && $stable(report_int)) else $error("locked unit took a command");
endmodule
bind tss_sequencer tss_sequencer_chk u_chk (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hwdata, .tape_eot, .tape_bot, .panel_clear, .tape_fwd, .tape_rev,
  .error_lamp, .interlock, .report_int, .unit_ready, .adapter_available);
`default_nettype wire

// *** verification/tape_search_transfer_sequencer_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tape_search_transfer_sequencer_tb_top;
  typedef struct packed {logic [3:0] op; logic [5:0] vc, c1, c2; logic [1:0] fnd; logic [4:0] p;}
    tss_row_t;
  localparam logic [5:0] mark = 6'h2a; // Arbitrary first char on tape
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic panel_clear = 1'b0;
  logic [4:0] err_blk = 5'h1f;
  logic [31:0] rd;
  wire [31:0] hrdata;
  wire [5:0] tape_char;
  wire [4:0] pos;
  wire hreadyout, hresp, tape_char_valid, tape_par_err, tape_gap, tape_eot, tape_bot;
  wire tape_fwd, tape_rev, error_lamp, interlock, report_int, unit_ready, adapter_available;
  int n_errors = 0;
  int n_tests = 0;
  int k;
  // Op, ident chars 0..2, {unequal, equal} find, tape position after
  tss_row_t rows [5] = '{'{4'h1, mark, 6'h05, 6'h05, 2'b01, 5'd5},
    '{4'h2, mark, 6'h03, 6'h3f, 2'b10, 5'd3}, '{4'h1, 6'h2b, 6'h04, 6'h00, 2'b00, 5'd16},
    '{4'h2, 6'h00, 6'h07, 6'h07, 2'b01, 5'd7}, '{4'h1, mark, 6'h3f, 6'h00, 2'b00, 5'd16}};
  always #5 hclk = ~hclk;
  tss_sequencer dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tape_char_valid(tape_char_valid),
    .tape_char(tape_char), .tape_par_err(tape_par_err), .tape_gap(tape_gap),
    .tape_eot(tape_eot), .tape_bot(tape_bot), .tape_eof(1'b0), .panel_clear(panel_clear),
    .tape_fwd(tape_fwd), .tape_rev(tape_rev), .error_lamp(error_lamp), .interlock(interlock),
    .report_int(report_int), .unit_ready(unit_ready), .adapter_available(adapter_available));
  tss_tape_model u_tape (.hclk(hclk), .hresetn(hresetn), .tape_fwd(tape_fwd),
    .tape_rev(tape_rev), .mark_char(mark), .err_blk(err_blk),
    .tape_char_valid(tape_char_valid), .tape_char(tape_char), .tape_par_err(tape_par_err),
    .tape_gap(tape_gap), .tape_eot(tape_eot), .tape_bot(tape_bot), .pos(pos));
  task automatic end_of_test;
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded wait for hready at a rising edge
  task automatic rdy;
    for (int i = 0; i < 9; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    n_errors++;
    end_of_test;
  endtask
  // One single word transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  task automatic cmd(input logic [3:0] op);
    bus(1'b1, 32'h0, 32'h20000000 | {28'h0, op});
    @(posedge hclk);
  endtask
  // Tape moves for thousands of cycles, so the bound is generous
  task automatic idle;
    for (int i = 0; i < 9000; i++) begin
      @(posedge hclk);
      if (!tape_fwd && !tape_rev) return; // Stopped, or hung not ready
    end
    n_errors++;
    end_of_test;
  endtask
  task automatic run(input logic [3:0] op);
    cmd(op);
    chk({report_int, adapter_available}, 2'b11);
    bus(1'b1, 32'h4, 32'h1);
    idle;
  endtask
  task automatic clr;
    panel_clear <= 1'b1;
    @(posedge hclk);
    panel_clear <= 1'b0;
    @(posedge hclk);
  endtask
  task automatic srch(input tss_row_t r);
    cmd(r.op);
    for (int w = 0; w < 24; w++) bus(1'b1, 32'h8, (w == 23) ? {2'b0, r.vc, r.c1, r.c2, 12'h0} : 0);
    @(posedge hclk);
    chk({report_int, adapter_available}, 2'b11);
    bus(1'b1, 32'h4, 32'h1);
    idle;
    bus(1'b0, 32'h4, 32'h0);
    chk(rd[4:3], r.fnd);
    chk(pos, r.p);
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    chk({adapter_available, unit_ready, report_int, tape_fwd, tape_rev, interlock, error_lamp,
      hresp}, 8'b11000000);
    chk(hrdata, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    cmd(4'h0);
    chk({report_int, tape_fwd, tape_rev}, 3'b100);
    bus(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h00000207);
    bus(1'b1, 32'h4, 32'h1);
    bus(1'b0, 32'h10, 32'h0);
    chk(rd, 32'h0);
    foreach (rows[i]) srch(rows[i]);
    // Buffer round trip, tape must stay put
    cmd(4'h4);
    for (k = 0; k < 24; k++) bus(1'b1, 32'h8, (k * 32'h00a5a5a5) & 32'h3fffffff);
    @(posedge hclk);
    chk({report_int, unit_ready, adapter_available, tape_fwd, tape_rev}, 5'b11100);
    bus(1'b1, 32'h4, 32'h1);
    cmd(4'h3);
    for (k = 0; k < 24; k++) begin
      bus(1'b0, 32'h8, 32'h0);
      chk(rd, (k * 32'h00a5a5a5) & 32'h3fffffff);
    end
    @(posedge hclk);
    chk({report_int, unit_ready, tape_fwd, tape_rev}, 4'b1100);
    bus(1'b1, 32'h4, 32'h1);
    // Rewind meets a bad blockette and hangs until the panel clears it
    err_blk <= 5'd12;
    run(4'h7);
    chk({error_lamp, unit_ready, tape_rev}, 3'b100);
    err_blk <= 5'h1f;
    clr;
    run(4'h8);
    chk({interlock, unit_ready, tape_bot}, 3'b101);
    cmd(4'h0);
    bus(1'b0, 32'h4, 32'h0);
    chk({rd[7], rd[0]}, 2'b10);
    clr;
    bus(1'b1, 32'h4, 32'h1);
    run(4'h6);
    chk({interlock, unit_ready, tape_eot}, 3'b101);
    clr;
    // Wind at end of tape hangs not ready
    run(4'h5);
    chk({unit_ready, tape_fwd}, 2'b00);
    clr;
    chk(unit_ready, 1'b1);
    end_of_test;
  end
endmodule
`default_nettype wire
